// *** bench/emc_mac_cfg_assertions.sv ***
// Purpose: port-level checks of the mac configuration block
// Assumes: one clock, reset active low
// Notes: register contents are not mirrored here, only read-back shape
`timescale 1ns/1ps
module emc_mac_cfg_chk import emc_pkg::*; (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire emc_sfr_req_t sfr_req_i,
  input wire logic [31:0] sfr_rdata_o,
  input wire logic sfr_rvalid_o,
  input wire logic crs_i,
  input wire logic phy_tx_en_o,
  input wire logic two_way_mode_o,
  input wire emc_stat_t tx_stat_o,
  input wire logic rx_valid_i,
  input wire emc_byte_t rx_byte_i,
  input wire emc_stat_t rx_stat_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_read_answer: assert property (sfr_req_i.rd |=> sfr_rvalid_o)
    else $error("read not answered");
  a_no_stray: assert property (!sfr_req_i.rd |=> !sfr_rvalid_o)
    else $error("read answer without read");
  a_byte_read: assert property (sfr_req_i.rd && sfr_req_i.size == EMC_SZ_BYTE |=> sfr_rdata_o == 32'h0)
    else $error("byte read returned data");
  a_ien_unused: assert property (sfr_req_i.rd && sfr_req_i.addr == 16'h2300 |=> (sfr_rdata_o & 32'hffff9c10) == 32'h0)
    else $error("unimplemented enable bit read as one");
  a_alias_read: assert property (sfr_req_i.rd && sfr_req_i.addr inside {16'h2304, 16'h2308, 16'h230c}
    |=> sfr_rdata_o == 32'h0)
    else $error("alias read returned data");
  a_duplex_hold: assert property (!sfr_req_i.wr [*2] |=> $stable(two_way_mode_o))
    else $error("duplex output moved without a write");
  a_carrier_defer: assert property ((!two_way_mode_o && crs_i && !phy_tx_en_o) [*6] |=> !phy_tx_en_o)
    else $error("half duplex sent over carrier");
  a_frame_end: assert property ($fell(phy_tx_en_o) |-> $past(tx_stat_o.done) || tx_stat_o.aborted)
    else $error("frame ended without status");
  a_over_abort: assert property (tx_stat_o.oversize |-> tx_stat_o.aborted && !tx_stat_o.done)
    else $error("oversize frame not aborted");
  a_rx_status: assert property (rx_valid_i && rx_byte_i.last |=> rx_stat_o.done)
    else $error("receive status missing");
  c_frame: cover property ($fell(phy_tx_en_o));
  c_oversize: cover property (tx_stat_o.oversize);
  c_mismatch: cover property (rx_stat_o.len_mismatch);
endmodule
bind emc_mac_cfg emc_mac_cfg_chk emc_mac_cfg_chk_i (.clk_i(clk_i), .resetn_i(resetn_i), .sfr_req_i(sfr_req_i),
  .sfr_rdata_o(sfr_rdata_o), .sfr_rvalid_o(sfr_rvalid_o), .crs_i(crs_i), .phy_tx_en_o(phy_tx_en_o),
  .two_way_mode_o(two_way_mode_o), .tx_stat_o(tx_stat_o), .rx_valid_i(rx_valid_i), .rx_byte_i(rx_byte_i),
  .rx_stat_o(rx_stat_o));

// *** bench/emc_mac_cfg_tb.sv ***
// Purpose: self-checking bench for the mac configuration block
// Assumes: phy model counts sent bytes and holds carrier on request
// Notes: registers, event gating, framing and receive length checks
`timescale 1ns/1ps
module emc_mac_cfg_tb import emc_pkg::*; ;
  logic clk_i = 0, resetn_i = 0, txv = 0, rxv = 0, busy = 0, clr = 1, crs, tdone, rvalid, irq, txr, txen, twm;
  logic [31:0] rdata, rdv;
  logic [7:0] txd;
  logic [EV_W-1:0] ev = '0;
  emc_sfr_req_t req = '0;
  emc_byte_t txb = '0, rxb = '0;
  emc_stat_t tst, rs, tlast;
  int n_errors = 0, num_checks = 0, nb;
  logic [31:0] cfg [9] = '{32'h31, 32'h71, 32'hb1, 32'hb1, 32'h51, 32'h01, 32'h39, 32'h01, 32'h05};
  logic tg [9] = '{0, 0, 1, 0, 1, 0, 0, 0, 0};
  int len [9] = '{14, 14, 14, 14, 14, 14, 14, 1520, 1520};
  int nw [9] = '{64, 68, 68, 64, 18, 14, 68, 0, 1520};
  logic [2:0] st [9] = '{3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h3, 3'h4};

  emc_mac_cfg emc_mac_cfg_i (.clk_i(clk_i), .resetn_i(resetn_i), .sfr_req_i(req), .sfr_rdata_o(rdata),
    .sfr_rvalid_o(rvalid), .ev_i(ev), .irq_o(irq), .tx_valid_i(txv), .tx_byte_i(txb), .tx_ready_o(txr),
    .crs_i(crs), .phy_txd_o(txd), .phy_tx_en_o(txen), .two_way_mode_o(twm), .tx_stat_o(tst),
    .rx_valid_i(rxv), .rx_byte_i(rxb), .rx_stat_o(rs));
  emc_phy_model emc_phy_model_i (.clk_i(clk_i), .tx_en_i(txen), .busy_i(busy), .clr_i(clr), .crs_o(crs), .n_o(nb));

  initial forever #10 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    if (clr)
      tdone <= 0;
    else if (tst.done || tst.aborted) begin
      tdone <= 1;
      tlast <= tst;
    end
  end

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic acc(logic w, logic [15:0] a, logic [31:0] d, emc_size_t s);
    req <= '{wr: w, rd: !w, size: s, addr: a, wdata: d};
    @(posedge clk_i);
    req <= '0;
    #1;
    rdv = rdata;
    @(posedge clk_i);
  endtask

  task automatic wr(logic [15:0] a, logic [31:0] d);
    acc(1, a, d, EMC_SZ_WORD);
  endtask

  task automatic rd(logic [15:0] a, logic [31:0] e);
    acc(0, a, 32'h0, EMC_SZ_WORD);
    chk("rdata", e, rdv);
  endtask

  task automatic wchk(logic [15:0] a, logic [31:0] d, emc_size_t s, logic [31:0] e);
    acc(1, a, d, s);
    rd(16'h2300, e);
  endtask

  task automatic pulse(logic [EV_W-1:0] v);
    wr(16'h2310, 32'h7fff);
    ev <= v;
    @(posedge clk_i);
    ev <= '0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  task automatic send(int n, logic t);
    clr <= 1;
    for (int i = 0; i < n; i++) begin
      txv <= 1;
      txb <= '{data: i == 12 ? (t ? 8'h81 : 8'h08) : i == 13 ? 8'h00 : i[7:0], last: i == n - 1};
      @(posedge clk_i);
      clr <= 0;
      while (!txr) @(posedge clk_i);
    end
    txv <= 0;
  endtask

  task automatic txwait();
    for (int k = 0; k < 3000 && tdone !== 1'b1; k++)
      @(posedge clk_i);
    #1;
  endtask

  task automatic rxf(logic [7:0] lf);
    for (int i = 0; i < 64; i++) begin
      rxv <= 1;
      rxb <= '{data: i == 13 ? lf : i == 12 ? 8'h00 : i[7:0], last: i == 63};
      @(posedge clk_i);
    end
    rxv <= 0;
    #1;
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge clk_i);
    resetn_i <= 1;
    @(posedge clk_i);
    for (int i = 0; i < REG_N; i++)
      rd(REG_OFS[i], REG_RST[i]);
    wchk(16'h2300, 32'hffffffff, EMC_SZ_WORD, 32'h63ef);
    wchk(16'h2304, 32'h0000000f, EMC_SZ_WORD, 32'h63e0);
    wchk(16'h230c, 32'h00004001, EMC_SZ_WORD, 32'h23e1);
    wchk(16'h2308, 32'h00004000, EMC_SZ_WORD, 32'h63e1);
    wchk(16'h2300, 32'h00000000, EMC_SZ_BYTE, 32'h63e1);
    wchk(16'h2302, 32'h00000000, EMC_SZ_HALF, 32'h63e1);
    wchk(16'h2300, 32'h00000000, EMC_SZ_HALF, 32'h0);
    rd(16'h2308, 32'h0);
    rd(16'h2400, 32'h0);
    $display("test registers done");
    for (int b = 0; b < EV_W; b++) begin
      wchk(16'h2300, 32'h1 << b, EMC_SZ_WORD, REG_MASK[R_IEN] & (32'h1 << b));
      pulse(~(15'h1 << b));
      chk("irq", 32'h0, irq);
      pulse(15'h1 << b);
      chk("irq", REG_MASK[R_IEN][b], irq);
    end
    wr(16'h2300, 32'h0);
    busy <= 1;
    $display("test events done");
    for (int i = 0; i < 9; i++) begin
      wr(16'h2210, cfg[i]);
      send(len[i], tg[i]);
      txwait();
      chk("status", st[i], {tlast.done, tlast.aborted, tlast.oversize});
      if (st[i] == 3'h4)
        chk("bytes", nw[i], nb);
    end
    $display("test framing done");
    wr(16'h2210, 32'h30);
    send(16, 0);
    @(posedge clk_i);
    #1;
    chk("ready", 32'h0, txr);
    chk("bytes", 32'h0, nb);
    chk("duplex", 32'h0, twm);
    busy <= 0;
    txwait();
    chk("bytes", 32'd64, nb);
    $display("test half duplex done");
    wr(16'h2210, 32'h3);
    for (int j = 0; j < 2; j++) begin
      rxf(j ? 8'h10 : 8'h2e);
      chk("mismatch", j, rs.len_mismatch);
    end
    $display("test receive done");
    end_of_test();
  end
endmodule

// *** bench/emc_phy_model.sv ***
// Purpose: phy stand-in counting bytes sent per frame
// Assumes: one byte per cycle while transmit enable is high
// Notes: carrier is raised on request to stall a half duplex sender
`timescale 1ns/1ps
module emc_phy_model (
  input wire logic clk_i,
  input wire logic tx_en_i,
  input wire logic busy_i,
  input wire logic clr_i,
  output logic crs_o,
  output int n_o
);
  // carrier held while the medium is busy, so the sender can be made slow
  assign crs_o = busy_i;
  always_ff @(posedge clk_i) begin
    if (clr_i)
      n_o <= 0;
    else if (tx_en_i)
      n_o <= n_o + 1;
  end
endmodule

// *** design/emc_mac_cfg.sv ***
// Purpose: mac frame-handling configuration, event enables and transmit framer
// Assumes: register port and frame streams on clk_i; carrier sense comes from a pin
// Notes: transmit bytes pass a 16-word fifo before the framer
//
// How it works
// - transmit bus fault event reaches irq only with enable bit 14 set.
// - receive bus fault event reaches irq only with enable bit 13 set.
// - low and high level mark events gated by enable bits 9 and 8.
// - receive finished, frame waiting, receive activity gated by bits 7, 6, 5.
// - send finished and send aborted events gated by bits 3 and 2.
// - no receive buffer and receive fifo overrun gated by bits 1 and 0.
// - transmit enables touch transmit events only, receive enables receive only.
// - unimplemented enable bits 31-15, 12-10 and 4 always read zero.
// - tagged fill with short fill on pads every short frame to 64; fcs only with fcs append.
// - tagged fill is ignored while short frame fill is off.
// - short fill on pads short frames; off sends frames as given.
// - fcs append adds crc to every frame; software sets it with fill.
// - oversize allow lifts the length limit on transmit and receive.
// - length check compares length field to payload, or on transmit with no pad and no fcs to the previous frame's length, and reports mismatches.
// - two way mode bit selects full duplex, zero selects half duplex.
// - fill on, tag aware and tagged fill off pads to 60 bytes.
// - tag aware fill pads untagged frames to 60, tagged frames to 64.
// - 16-bit and 32-bit accesses work, 8-bit accesses are ignored.
// - clear, set, invert aliases at +4, +8, +c change only written ones.
`timescale 1ns/1ps

// ------------------------------------------------------------------
// fifo
// ------------------------------------------------------------------
module emc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  logic ready_r;
  wire push = in_valid_i && ready_r;
  wire pop = out_ready_i && (cnt_r != '0);

  assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready_o = ready_r;
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem_r[rptr_r];

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r <= '0;
      ready_r <= 1'b0;
    end else begin
      wptr_r <= wptr_r + AW'(push);
      rptr_r <= rptr_r + AW'(pop);
      cnt_r <= cnt_nxt;
      ready_r <= (cnt_nxt != FULL_CNT);
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wptr_r] <= in_data_i;
    end
  end
endmodule

// ------------------------------------------------------------------
// top
// ------------------------------------------------------------------
module emc_mac_cfg
  import emc_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire emc_sfr_req_t sfr_req_i,
  output logic [31:0] sfr_rdata_o,
  output logic sfr_rvalid_o,
  input wire logic [EV_W-1:0] ev_i,
  output logic irq_o,
  input wire logic tx_valid_i,
  input wire emc_byte_t tx_byte_i,
  output logic tx_ready_o,
  input wire logic crs_i,
  output logic [7:0] phy_txd_o,
  output logic phy_tx_en_o,
  output logic two_way_mode_o,
  output emc_stat_t tx_stat_o,
  input wire logic rx_valid_i,
  input wire emc_byte_t rx_byte_i,
  output emc_stat_t rx_stat_o
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // frame payload compared with the length field; type values never mismatch
  function automatic logic len_bad(input logic chk, input logic [LEN_W-1:0] fld,
                                   input logic [LEN_W-1:0] n);
    return chk && (fld < TYPE_MIN) && (n >= MAC_HDR_LEN) && (fld != LEN_W'(n - MAC_HDR_LEN));
  endfunction

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  logic [31:0] reg_r [REG_N];
  logic [EV_W-1:0] flag_r;
  logic [31:0] rdata_r;
  logic rvalid_r;
  logic irq_r;

  wire [ADDR_W-1:0] base_addr = {sfr_req_i.addr[ADDR_W-1:4], 4'h0};
  wire [1:0] alias_sel = sfr_req_i.addr[3:2];
  // byte accesses get an empty lane mask, so they neither write nor read
  // size decode
  wire [31:0] lane = (sfr_req_i.size == EMC_SZ_WORD) ? LANE_ALL :
                     (sfr_req_i.size == EMC_SZ_HALF) ? (sfr_req_i.addr[1] ? LANE_HI : LANE_LO) : '0;
  wire size_ok = (lane != '0);
  wire stat_hit = (sfr_req_i.addr == STAT_OFS);
  logic [REG_N-1:0] hit;

  always_comb begin
    for (int k = 0; k < REG_N; k++) begin
      hit[k] = (base_addr == REG_OFS[k]);
    end
  end

  wire [31:0] cfg = reg_r[R_CFG2];
  wire [31:0] ien = reg_r[R_IEN];

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [31:0] reg_nxt [REG_N];
  logic [31:0] rdata_nxt;

  always_comb begin
    rdata_nxt = '0;
    for (int k = 0; k < REG_N; k++) begin
      reg_nxt[k] = reg_r[k];
      if (sfr_req_i.wr && size_ok && hit[k]) begin
        if (alias_sel == ALIAS_CLR) begin
          reg_nxt[k] = reg_r[k] & ~(sfr_req_i.wdata & lane);
        end else if (alias_sel == ALIAS_SET) begin
          reg_nxt[k] = reg_r[k] | (sfr_req_i.wdata & lane);
        end else if (alias_sel == ALIAS_INV) begin
          reg_nxt[k] = reg_r[k] ^ (sfr_req_i.wdata & lane);
        end else begin
          reg_nxt[k] = (reg_r[k] & ~lane) | (sfr_req_i.wdata & lane);
        end
      end
      reg_nxt[k] = reg_nxt[k] & REG_MASK[k];
      if (sfr_req_i.rd && size_ok && hit[k] && (alias_sel == ALIAS_NONE)) begin
        rdata_nxt = reg_r[k];
      end
    end
    if (sfr_req_i.rd && size_ok && stat_hit) begin
      rdata_nxt = 32'(flag_r);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int k = 0; k < REG_N; k++) begin
        reg_r[k] <= REG_RST[k];
      end
      rdata_r <= '0;
      rvalid_r <= 1'b0;
    end else begin
      reg_r <= reg_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= sfr_req_i.rd;
    end
  end

  // ----------------------------------------------------------------
  // carrier sense synchroniser
  // ----------------------------------------------------------------
  logic [2:0] crs_sync_r;
  logic crs_r;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      crs_sync_r <= '0;
      crs_r <= 1'b0;
    end else begin
      crs_sync_r <= {crs_sync_r[1:0], crs_i};
      if (crs_sync_r[2] == crs_sync_r[1]) begin
        crs_r <= crs_sync_r[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // transmit fifo
  // ----------------------------------------------------------------
  logic fo_valid;
  logic fo_ready;
  emc_byte_t fo_byte;

  emc_fifo #(
    .WIDTH($bits(emc_byte_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .in_data_i(tx_byte_i),
    .out_valid_o(fo_valid),
    .out_ready_i(fo_ready),
    .out_data_o(fo_byte)
  );

  // ----------------------------------------------------------------
  // transmit framer
  // ----------------------------------------------------------------
  emc_tx_st_t st_r, st_nxt;
  logic [LEN_W-1:0] len_r, len_nxt;
  logic [2:0] hdr_r, hdr_nxt;
  logic [31:0] crc_r, crc_nxt;
  logic [7:0] type_hi_r, type_hi_nxt;
  logic [LEN_W-1:0] fld_r, fld_nxt;
  logic tagged_r, tagged_nxt;
  logic [LEN_W-1:0] fill_r, fill_nxt;
  logic [1:0] fcs_idx_r, fcs_idx_nxt;
  logic [7:0] txd_nxt;
  logic txen_nxt;
  logic tx_done, tx_abort;
  emc_stat_t tx_stat_nxt;

  // half duplex defers to carrier, full duplex ignores it
  wire may_start = cfg[B_TWO_WAY] || !crs_r;
  // length ceiling unless oversize frames are allowed
  wire over_lim = !cfg[B_OVERSIZE] && ((len_r + FCS_LEN) >= MAX_FRAME);
  // first bytes form a header kept out of the crc
  wire in_hdr = cfg[B_SKIP_HDR] && (hdr_r != HDR_SKIP_N);
  wire is_tag = (st_r == TX_DATA) && (len_r == POS_TYPE_LO) && (type_hi_r == VLAN_HI) && (fo_byte.data == VLAN_LO);
  // tag aware fill picks by tag
  // tag bits only read under fill on
  wire [LEN_W-1:0] fill_tgt = (cfg[B_TAGGED_64] || (cfg[B_TAG_AWARE] && (tagged_r || is_tag))) ? FILL_64 : FILL_60;
  wire [LEN_W-1:0] len_inc = len_r + 16'h0001;
  wire need_fill = cfg[B_FILL_ON] && (len_inc < fill_tgt);

  assign fo_ready = (st_r == TX_DATA) || (st_r == TX_DROP);

  always_comb begin
    st_nxt = st_r;
    len_nxt = len_r;
    hdr_nxt = hdr_r;
    crc_nxt = crc_r;
    type_hi_nxt = type_hi_r;
    fld_nxt = fld_r;
    tagged_nxt = tagged_r;
    fill_nxt = fill_r;
    fcs_idx_nxt = fcs_idx_r;
    txd_nxt = '0;
    txen_nxt = 1'b0;
    tx_done = 1'b0;
    tx_abort = 1'b0;
    case (st_r)
      TX_IDLE: begin
        len_nxt = '0;
        hdr_nxt = '0;
        crc_nxt = CRC_INIT;
        tagged_nxt = 1'b0;
        fld_nxt = '0;
        fcs_idx_nxt = '0;
        if (fo_valid && may_start) begin
          st_nxt = TX_DATA;
        end
      end
      TX_DATA: begin
        if (!fo_valid) begin
          // underrun: the wire cannot pause, so the frame is cut
          tx_abort = 1'b1;
          st_nxt = TX_DROP;
        end else if (over_lim && !in_hdr) begin
          tx_abort = 1'b1;
          st_nxt = fo_byte.last ? TX_IDLE : TX_DROP;
        end else begin
          txd_nxt = fo_byte.data;
          txen_nxt = 1'b1;
          if (in_hdr) begin
            hdr_nxt = hdr_r + 3'h1;
          end else begin
            crc_nxt = crc_byte(crc_r, fo_byte.data);
            len_nxt = len_inc;
            if (len_r == POS_TYPE_HI) begin
              type_hi_nxt = fo_byte.data;
            end
            if (len_r == POS_TYPE_LO) begin
              fld_nxt = {type_hi_r, fo_byte.data};
              tagged_nxt = is_tag;
            end
          end
          if (fo_byte.last) begin
            fill_nxt = in_hdr ? len_r : len_inc;
            if (need_fill && !in_hdr) begin
              st_nxt = TX_PAD;
            end else if (cfg[B_FCS_ON]) begin
              st_nxt = TX_FCS;
            end else begin
              tx_done = 1'b1;
              st_nxt = TX_IDLE;
            end
          end
        end
      end
      TX_PAD: begin
        txd_nxt = '0;
        txen_nxt = 1'b1;
        crc_nxt = crc_byte(crc_r, 8'h00);
        len_nxt = len_inc;
        if (!need_fill) begin
          if (cfg[B_FCS_ON]) begin
            st_nxt = TX_FCS;
          end else begin
            tx_done = 1'b1;
            st_nxt = TX_IDLE;
          end
        end
      end
      TX_FCS: begin
        txd_nxt = ~crc_r[8*fcs_idx_r +: 8];
        txen_nxt = 1'b1;
        fcs_idx_nxt = fcs_idx_r + 2'h1;
        if (fcs_idx_r == FCS_LAST) begin
          tx_done = 1'b1;
          st_nxt = TX_IDLE;
        end
      end
      TX_DROP: begin
        if (fo_valid && fo_byte.last) begin
          st_nxt = TX_IDLE;
        end
      end
      default: begin
        st_nxt = TX_IDLE;
      end
    endcase
  end

  always_comb begin
    tx_stat_nxt = '0;
    tx_stat_nxt.done = tx_done;
    tx_stat_nxt.aborted = tx_abort;
    tx_stat_nxt.oversize = tx_abort && over_lim;
    tx_stat_nxt.len_mismatch = tx_done && len_bad(cfg[B_LEN_CHK], fld_r, fill_r);
    tx_stat_nxt.length = (tx_done || tx_abort) ? len_r : '0;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= TX_IDLE;
      len_r <= '0;
      hdr_r <= '0;
      crc_r <= CRC_INIT;
      type_hi_r <= '0;
      fld_r <= '0;
      tagged_r <= 1'b0;
      fill_r <= '0;
      fcs_idx_r <= '0;
      phy_txd_o <= '0;
      phy_tx_en_o <= 1'b0;
      tx_stat_o <= '0;
    end else begin
      st_r <= st_nxt;
      len_r <= len_nxt;
      hdr_r <= hdr_nxt;
      crc_r <= crc_nxt;
      type_hi_r <= type_hi_nxt;
      fld_r <= fld_nxt;
      tagged_r <= tagged_nxt;
      fill_r <= fill_nxt;
      fcs_idx_r <= fcs_idx_nxt;
      phy_txd_o <= txd_nxt;
      phy_tx_en_o <= txen_nxt;
      tx_stat_o <= tx_stat_nxt;
    end
  end

  // ----------------------------------------------------------------
  // receive length monitor
  // ----------------------------------------------------------------
  logic [LEN_W-1:0] rx_len_r;
  logic [2:0] rx_hdr_r;
  logic [7:0] rx_hi_r;
  logic [LEN_W-1:0] rx_fld_r;
  logic rx_over_r;
  emc_stat_t rx_stat_nxt;

  wire rx_in_hdr = cfg[B_SKIP_HDR] && (rx_hdr_r != HDR_SKIP_N);
  wire [LEN_W-1:0] rx_len_inc = rx_len_r + 16'h0001;
  // receive ceiling, received frames carry their fcs
  wire rx_over = rx_over_r || (!cfg[B_OVERSIZE] && !rx_in_hdr && (rx_len_inc > MAX_FRAME));
  wire rx_end = rx_valid_i && rx_byte_i.last;
  wire [LEN_W-1:0] rx_final = rx_in_hdr ? rx_len_r : rx_len_inc;

  // receive length check, fcs bytes excluded
  always_comb begin
    rx_stat_nxt = '0;
    rx_stat_nxt.done = rx_end;
    rx_stat_nxt.oversize = rx_end && rx_over;
    rx_stat_nxt.len_mismatch = rx_end && (rx_final >= FCS_LEN) &&
                               len_bad(cfg[B_LEN_CHK], rx_fld_r, LEN_W'(rx_final - FCS_LEN));
    rx_stat_nxt.length = rx_end ? rx_final : '0;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_len_r <= '0;
      rx_hdr_r <= '0;
      rx_hi_r <= '0;
      rx_fld_r <= '0;
      rx_over_r <= 1'b0;
      rx_stat_o <= '0;
    end else begin
      rx_stat_o <= rx_stat_nxt;
      if (rx_end) begin
        rx_len_r <= '0;
        rx_hdr_r <= '0;
        rx_fld_r <= '0;
        rx_over_r <= 1'b0;
      end else if (rx_valid_i) begin
        rx_over_r <= rx_over;
        if (rx_in_hdr) begin
          rx_hdr_r <= rx_hdr_r + 3'h1;
        end else begin
          rx_len_r <= rx_len_inc;
          if (rx_len_r == POS_TYPE_HI) begin
            rx_hi_r <= rx_byte_i.data;
          end
          if (rx_len_r == POS_TYPE_LO) begin
            rx_fld_r <= {rx_hi_r, rx_byte_i.data};
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // event flags and interrupt request
  // ----------------------------------------------------------------
  logic [EV_W-1:0] ev_all;
  logic [EV_W-1:0] flag_nxt;

  always_comb begin
    ev_all = ev_i;
    ev_all[EV_TX_DONE] = ev_i[EV_TX_DONE] || tx_done;
    ev_all[EV_TX_ABORT] = ev_i[EV_TX_ABORT] || tx_abort;
    ev_all[EV_RX_DONE] = ev_i[EV_RX_DONE] || rx_end;
    ev_all[EV_RX_ACT] = ev_i[EV_RX_ACT] || rx_valid_i;
    flag_nxt = flag_r;
    // a write of ones to the status word clears flags; a new event wins
    if (sfr_req_i.wr && size_ok && stat_hit) begin
      flag_nxt = flag_r & ~EV_W'(sfr_req_i.wdata & lane);
    end
    flag_nxt = (flag_nxt | ev_all) & EV_W'(REG_MASK[R_IEN]);
  end

  // each enable pairs with its own event only
  wire irq_nxt = |(flag_r & EV_W'(ien));

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_r <= '0;
      irq_r <= 1'b0;
      two_way_mode_o <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      irq_r <= irq_nxt;
      two_way_mode_o <= cfg[B_TWO_WAY];
    end
  end

  assign irq_o = irq_r;
  assign sfr_rdata_o = rdata_r;
  assign sfr_rvalid_o = rvalid_r;

endmodule

// *** design/emc_pkg.sv ***
// Purpose: shared constants, types and register map of the mac configuration block
// Assumes: one 50 MHz clock, byte-wide frame streams
// Notes: offsets are the low 16 bits of the special-function-register address
package emc_pkg;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int REG_N = 7;
  localparam logic [1:0] ALIAS_NONE = 2'h0;
  localparam logic [1:0] ALIAS_CLR = 2'h1;
  localparam logic [1:0] ALIAS_SET = 2'h2;
  localparam logic [1:0] ALIAS_INV = 2'h3;
  localparam logic [31:0] LANE_ALL = 32'hffffffff;
  localparam logic [31:0] LANE_LO = 32'h0000ffff;
  localparam logic [31:0] LANE_HI = 32'hffff0000;

  typedef enum logic [1:0] {
    EMC_SZ_BYTE = 2'b00,
    EMC_SZ_HALF = 2'b01,
    EMC_SZ_WORD = 2'b10
  } emc_size_t;

  typedef struct packed {
    logic wr;
    logic rd;
    emc_size_t size;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } emc_sfr_req_t;

  // register indices
  localparam int R_CFG2 = 0;
  localparam int R_SUPP = 1;
  localparam int R_TEST = 2;
  localparam int R_MCFG = 3;
  localparam int R_MCMD = 4;
  localparam int R_MADR = 5;
  localparam int R_IEN = 6;

  localparam logic [ADDR_W-1:0] REG_OFS [REG_N] = '{16'h2210, 16'h2260, 16'h2270, 16'h2280,
                                                    16'h2290, 16'h22a0, 16'h2300};
  localparam logic [31:0] REG_MASK [REG_N] = '{32'h000073ff, 32'h00001900, 32'h00000007, 32'h0000803f,
                                               32'h00000003, 32'h00001f1f, 32'h000063ef};
  localparam logic [31:0] REG_RST [REG_N] = '{32'h00004082, 32'h00001000, 32'h00000000, 32'h00000020,
                                              32'h00000000, 32'h00000100, 32'h00000000};
  // status register has no clear, set or invert aliases
  localparam logic [ADDR_W-1:0] STAT_OFS = 16'h2310;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int B_TAG_AWARE = 7;
  localparam int B_TAGGED_64 = 6;
  localparam int B_FILL_ON = 5;
  localparam int B_FCS_ON = 4;
  localparam int B_SKIP_HDR = 3;
  localparam int B_OVERSIZE = 2;
  localparam int B_LEN_CHK = 1;
  localparam int B_TWO_WAY = 0;
  localparam int EV_W = 15;
  localparam int EV_RX_DONE = 7;
  localparam int EV_RX_ACT = 5;
  localparam int EV_TX_DONE = 3;
  localparam int EV_TX_ABORT = 2;
  localparam logic [EV_W-1:0] TX_EV_MASK = 15'h400c;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int LEN_W = 16;
  localparam logic [LEN_W-1:0] FILL_60 = 16'h003c;
  localparam logic [LEN_W-1:0] FILL_64 = 16'h0040;
  localparam logic [LEN_W-1:0] MAX_FRAME = 16'h05ee;
  localparam logic [LEN_W-1:0] FCS_LEN = 16'h0004;
  localparam logic [LEN_W-1:0] MAC_HDR_LEN = 16'h000e;
  localparam logic [LEN_W-1:0] POS_TYPE_HI = 16'h000c;
  localparam logic [LEN_W-1:0] POS_TYPE_LO = 16'h000d;
  localparam logic [LEN_W-1:0] TYPE_MIN = 16'h0600;
  localparam logic [7:0] VLAN_HI = 8'h81;
  localparam logic [7:0] VLAN_LO = 8'h00;
  localparam logic [2:0] HDR_SKIP_N = 3'h4;
  localparam logic [1:0] FCS_LAST = 2'h3;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam int FIFO_DEPTH = 16;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } emc_byte_t;

  typedef struct packed {
    logic done;
    logic aborted;
    logic oversize;
    logic len_mismatch;
    logic [LEN_W-1:0] length;
  } emc_stat_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_DATA = 3'b001,
    TX_PAD = 3'b010,
    TX_FCS = 3'b011,
    TX_DROP = 3'b100
  } emc_tx_st_t;

endpackage
